// >>> dv/aib_regs_properties.sv
`timescale 1ns/100ps
module aib_regs_chk
   import aib_pkg::*;
#(
   parameter logic [1:0] DIE_REV   = 2'h2,
   parameter logic [1:0] PKG_MODEL = 2'h3
) (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [5:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        data_ready_i,
   input wire logic [11:0] fault_event_i,
   input wire logic [11:0] fault_enable_i,
   input wire logic        pos_input_range_fault_i,
   input wire logic [2:0]  pin_drive_o,
   input wire logic [2:0]  pin_oe_n_o,
   input wire logic [2:0]  pin_input_role_o,
   input wire logic [15:0] bias_voltage_output_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic wr_b, rd_f, rd_id;
   assign wr_b  = reg_wr_i && reg_addr_i == ADDR_BIAS_EN;
   assign rd_f  = reg_rd_i && reg_addr_i == ADDR_FAULT;
   assign rd_id = reg_rd_i && reg_addr_i == ADDR_DEV_ID;
   sequence s_route;
      reg_wr_i && reg_addr_i == ADDR_IO_CTRL && reg_wdata_i[9:8] == 2'h2
      ##1 !reg_wr_i;
   endsequence
   sequence s_set0;
      fault_event_i[0] && fault_enable_i[0] ##1 rd_f;
   endsequence
   sequence s_set11;
      pos_input_range_fault_i && fault_enable_i[11] ##1 rd_f;
   endsequence
   a_bias_write: assert property (wr_b |=> bias_voltage_output_o == $past(reg_wdata_i)) else $error("bias write lost");
   a_bias_hold: assert property (!wr_b |=> $stable(bias_voltage_output_o)) else $error("bias changed");
   a_id_read: assert property (rd_id |=> reg_rdata_o == {12'h000, DIE_REV, PKG_MODEL}) else $error("bad id");
   a_fault_top: assert property (rd_f |=> reg_rdata_o[15:12] == 4'h0) else $error("fault top set");
   a_role_oe: assert property (pin_input_role_o == pin_oe_n_o) else $error("role mismatch");
   a_route_pin: assert property (s_route |-> pin_drive_o[1] == data_ready_i && !pin_oe_n_o[1]) else $error("no route");
   a_flag_set: assert property (s_set0 |=> reg_rdata_o[0]) else $error("flag not set");
   a_pos_fault: assert property (s_set11 |=> reg_rdata_o[11]) else $error("pos flag");
endmodule : aib_regs_chk
bind aib_regs aib_regs_chk #(.DIE_REV(DIE_REV), .PKG_MODEL(PKG_MODEL)) u_chk (.*);

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import aib_pkg::*;
   localparam logic [1:0] REV = 2'h2; // Arbitrary value
   localparam logic [1:0] MDL = 2'h3; // Arbitrary value
   logic        clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic        data_ready_i = 0, pos_input_range_fault_i = 0, reg_rvalid_o;
   logic [5:0]  reg_addr_i = 0;
   logic [15:0] reg_wdata_i = 0, reg_rdata_o, bias_voltage_output_o;
   logic [11:0] fault_event_i = 0, fault_enable_i = 0;
   logic [2:0]  pin_drive_o, pin_oe_n_o, pin_input_role_o;
   int          err_count = 0, samples_checked = 0;
   aib_regs #(.DIE_REV(REV), .PKG_MODEL(MDL)) u_aib_regs (.*);
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask : wr
   task rd(input logic [5:0] a, input logic [15:0] e);
      @(negedge clk_i);
      {reg_rd_i, reg_addr_i} = {1'b1, a};
      @(negedge clk_i);
      reg_rd_i = 0;
      chk({15'h0, reg_rvalid_o}, 16'h0001);
      chk(reg_rdata_o, e);
   endtask : rd
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (2000) @(posedge clk_i);
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (12) @(negedge clk_i);
      nrst_i = 1;
      rd(ADDR_BIAS_EN, 16'h0000);
      rd(ADDR_FAULT, 16'h0000);
      chk({13'h0, pin_input_role_o}, 16'h0007);
      chk({13'h0, pin_oe_n_o}, 16'h0007);
      chk({13'h0, pin_drive_o}, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_BIAS_EN, 16'h0001 << i);
         chk(bias_voltage_output_o, 16'h0001 << i);
      end
      wr(ADDR_BIAS_EN, 16'hA5C3);
      rd(ADDR_BIAS_EN, 16'hA5C3);
      wr(ADDR_DEV_ID, 16'hFFFF);
      rd(ADDR_DEV_ID, {12'h000, REV, MDL});
      $display("test bias and id done");
      wr(ADDR_IO_CTRL, 16'h0057);
      chk({13'h0, pin_oe_n_o}, 16'h0000);
      chk({13'h0, pin_drive_o}, 16'h0005);
      wr(ADDR_IO_CTRL, 16'h0200);
      data_ready_i = 1;
      #1 chk({13'h0, pin_drive_o}, 16'h0002);
      chk({13'h0, pin_oe_n_o}, 16'h0005);
      $display("test pins done");
      fault_enable_i = 12'hFF7;
      fault_event_i = 12'h7FF;
      pos_input_range_fault_i = 1;
      rd(ADDR_FAULT, 16'h0FF7);
      {fault_event_i, pos_input_range_fault_i} = 0;
      wr(ADDR_FAULT, 16'h0005);
      rd(ADDR_FAULT, 16'h0FF2);
      fault_event_i = 12'h002;
      wr(ADDR_FAULT, 16'h0002);
      fault_event_i = 0;
      rd(ADDR_FAULT, 16'h0FF2);
      wr(ADDR_FAULT, 16'hFFFF);
      rd(ADDR_FAULT, 16'h0000);
      $display("test faults done");
      print_verdict();
   end
endmodule : tb_top

// >>> rtl/aib_flag_cell.sv
`timescale 1ns/100ps
module aib_flag_cell (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic event_i,
   input  wire logic enable_i,
   input  wire logic clear_i,
   output logic      flag_o
);
   logic flag_q;
   logic flag_d;

   always_comb begin
      flag_d = flag_q;
      if (clear_i) begin
         flag_d = 1'b0;
      end
      if (event_i && enable_i) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule : aib_flag_cell

// >>> rtl/aib_pkg.sv
package aib_pkg;
   localparam int         ADDR_W          = 6;
   localparam int         DATA_W          = 16;
   localparam int         BIAS_INPUTS     = 16;
   localparam int         FAULT_FLAGS     = 12;
   localparam int         IO_CTRL_W       = 11;

   localparam logic [5:0] ADDR_IO_CTRL    = 6'h03;
   localparam logic [5:0] ADDR_BIAS_EN    = 6'h04;
   localparam logic [5:0] ADDR_DEV_ID     = 6'h05;
   localparam logic [5:0] ADDR_FAULT      = 6'h06;

   localparam logic [10:0] IO_CTRL_RST    = 11'h000;
   localparam logic [15:0] BIAS_EN_RST    = 16'h0000;
   localparam logic [11:0] FAULT_RST      = 12'h000;

   // Pin io settings field positions
   localparam int         POS_PIN_ONE_SEL = 0;
   localparam int         POS_PIN_TWO_SEL = 1;
   localparam int         POS_PIN_THR_SEL = 2;
   localparam int         POS_DATA_LO     = 4;
   localparam int         POS_INT_SEL_LO  = 8;
   localparam int         POS_INT_SEL_HI  = 9;
   localparam logic [1:0] INT_SEL_PIN_TWO = 2'h2;

   // Pin slot indices (general pins one to three)
   localparam int         PIN_ONE         = 0;
   localparam int         PIN_TWO         = 1;
   localparam int         PIN_THREE       = 2;

   // Analog input served by each general pin
   localparam int         AIN_PIN_ONE     = 2;
   localparam int         AIN_PIN_TWO     = 3;
   localparam int         AIN_PIN_THREE   = 4;

   // Device identification fields
   localparam int         POS_REV_LO      = 2;
   localparam logic [3:0] ID_RESERVED     = 4'h0;

   localparam int         POS_POS_FAULT   = 11;
endpackage : aib_pkg

// >>> rtl/aib_regs.sv
`timescale 1ns/100ps
// Behaviour
// - Direction bit: 0 input role, 1 output
// - Pins one..three serve analog inputs 2..4
// - Pin two interrupt routing overrides other roles
// - Sixteen read/write bias enable bits per input
// - Bias enable at 0x04, resets to zero
// - Read-only id at 0x05, upper nibble zero
// - Id holds revision [3:2], model [1:0]
// - Fault register 0x06, write one clears
// - Fault flags set only when enabled
// - Bit 11 flags positive input range fault
// - Fault register resets to all zeros
// - Interrupt select 10 routes onto pin two
module aib_regs
   import aib_pkg::*;
#(
   parameter int         N_BIAS    = BIAS_INPUTS,
   parameter int         N_FAULT   = FAULT_FLAGS,
   // Arbitrary value
   parameter logic [1:0] DIE_REV   = 2'h2,
   // Arbitrary value
   parameter logic [1:0] PKG_MODEL = 2'h3
) (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   output logic                   reg_rvalid_o,
   input  wire logic              data_ready_i,
   input  wire logic [N_FAULT-1:0] fault_event_i,
   input  wire logic [N_FAULT-1:0] fault_enable_i,
   input  wire logic              pos_input_range_fault_i,
   output logic      [2:0]        pin_drive_o,
   output logic      [2:0]        pin_oe_n_o,
   output logic      [2:0]        pin_input_role_o,
   output logic      [N_BIAS-1:0] bias_voltage_output_o
);
   initial begin
      if (N_BIAS != BIAS_INPUTS || N_FAULT != FAULT_FLAGS) begin
         $error("aib_regs: unsupported width");
      end
   end

   logic [IO_CTRL_W-1:0] io_ctrl_q;
   logic [N_BIAS-1:0]    bias_en_q;
   logic [N_FAULT-1:0]   fault_q;
   logic [N_FAULT-1:0]   fault_evt;
   logic [N_FAULT-1:0]   fault_clr;
   logic [DATA_W-1:0]    rdata_q;
   logic [DATA_W-1:0]    rdata_d;
   logic                 rvalid_q;
   logic [2:0]           dir_q;
   logic [2:0]           data_q;
   logic                 int_on_pin_two;
   logic                 wr_fault;

   assign dir_q = {io_ctrl_q[POS_PIN_THR_SEL],
                   io_ctrl_q[POS_PIN_TWO_SEL],
                   io_ctrl_q[POS_PIN_ONE_SEL]};
   assign data_q = io_ctrl_q[POS_DATA_LO +: 3];
   assign int_on_pin_two =
      (io_ctrl_q[POS_INT_SEL_HI:POS_INT_SEL_LO] == INT_SEL_PIN_TWO);

   // Pin io settings
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         io_ctrl_q <= IO_CTRL_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_IO_CTRL) begin
         io_ctrl_q <= reg_wdata_i[IO_CTRL_W-1:0];
      end
   end

   // Pin roles: slot k is analog input AIN_PIN_ONE + k
   always_comb begin
      pin_drive_o      = data_q;
      pin_oe_n_o       = ~dir_q;
      pin_input_role_o = ~dir_q;
      if (int_on_pin_two) begin
         pin_drive_o[PIN_TWO]      = data_ready_i;
         pin_oe_n_o[PIN_TWO]       = 1'b0;
         pin_input_role_o[PIN_TWO] = 1'b0;
      end
   end

   // Input bias enable
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bias_en_q <= BIAS_EN_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_BIAS_EN) begin
         bias_en_q <= reg_wdata_i[N_BIAS-1:0];
      end
   end

   assign bias_voltage_output_o = bias_en_q;

   // Fault flags
   assign wr_fault = reg_wr_i && (reg_addr_i == ADDR_FAULT);

   always_comb begin
      fault_evt = fault_event_i;
      fault_evt[POS_POS_FAULT] = pos_input_range_fault_i;
      fault_clr = wr_fault ? reg_wdata_i[N_FAULT-1:0] : '0;
   end

   for (genvar i = 0; i < N_FAULT; i++) begin : g_fault
      aib_flag_cell u_cell (
         .clk_i    (clk_i),
         .nrst_i   (nrst_i),
         .event_i  (fault_evt[i]),
         .enable_i (fault_enable_i[i]),
         .clear_i  (fault_clr[i]),
         .flag_o   (fault_q[i])
      );
   end

   // Read path
   always_comb begin
      rdata_d = '0;
      unique case (reg_addr_i)
         ADDR_IO_CTRL: rdata_d[IO_CTRL_W-1:0] = io_ctrl_q;
         ADDR_BIAS_EN: rdata_d[N_BIAS-1:0]    = bias_en_q;
         ADDR_DEV_ID:  rdata_d[7:0] = {ID_RESERVED, DIE_REV,
                                       PKG_MODEL};
         ADDR_FAULT:   rdata_d[N_FAULT-1:0]   = fault_q;
         default:      rdata_d = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign reg_rvalid_o = rvalid_q;
endmodule : aib_regs
